// File: hdl/column_scan_sar_sequencer.sv
// Column scan sequencer with ten parallel SAR row channels
`timescale 1ns/10ps
module column_scan_sar_sequencer
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic measure_go_set_i,
  input wire logic scan_repeat_select_i,
  input wire logic [col_scan_pkg::ADDR_W-1:0] col_first_i,
  input wire logic [col_scan_pkg::ADDR_W-1:0] col_last_i,
  output logic measure_go_o,
  output logic busy_o,
  // Analog side
  input wire logic [col_scan_pkg::NUM_ROWS-1:0] cmp_i,
  output logic [col_scan_pkg::NUM_COLS-1:0] col_sel_o,
  output logic [col_scan_pkg::NUM_ROWS*col_scan_pkg::RES_BITS-1:0] dac_o,
  // Host readout
  input wire logic [col_scan_pkg::ADDR_W-1:0] rd_row_i,
  output logic [col_scan_pkg::RES_BITS-1:0] rd_data_o,
  output logic [col_scan_pkg::ADDR_W-1:0] rd_row_o,
  output logic [col_scan_pkg::ADDR_W-1:0] rd_col_o,
  output logic rd_valid_o,
  output logic col_done_o
);
  import col_scan_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Sampled pin inputs
  logic [NUM_ROWS-1:0] cmp_m_r, cmp_s_r;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmp_m_r <= '0;
      cmp_s_r <= '0;
    end else begin
      cmp_m_r <= cmp_i;
      cmp_s_r <= cmp_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  scan_state_t state_r, state_nxt;
  logic [NUM_COLS-1:0] sel_r, sel_nxt;
  logic [ADDR_W-1:0] col_r, col_nxt;
  logic [ADDR_W-1:0] load_cnt_r, load_cnt_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic go_r, go_nxt;
  logic sar_start, sar_step;
  logic [NUM_ROWS-1:0] ch_done;
  logic [RES_BITS-1:0] ch_res [NUM_ROWS];
  logic [ADDR_W-1:0] first_c, last_c;

  // Out-of-range limits fall back to the full matrix
  assign first_c = (col_first_i < ADDR_W'(NUM_COLS)) ? col_first_i : COL_FIRST_RST;
  assign last_c = (col_last_i < ADDR_W'(NUM_COLS) && col_last_i >= first_c) ? col_last_i : COL_LAST_RST;

  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    col_nxt = col_r;
    load_cnt_nxt = load_cnt_r;
    tmr_nxt = tmr_r;
    go_nxt = go_r | measure_go_set_i;
    sar_start = 1'b0;
    sar_step = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (go_r) begin
          go_nxt = measure_go_set_i;
          sel_nxt = SEL_RST;
          col_nxt = first_c;
          load_cnt_nxt = '0;
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // One bit per shift cycle: a one enters at the first column position
        sel_nxt = {sel_r[NUM_COLS-2:0], (load_cnt_r == ADDR_W'(NUM_COLS-1) - col_r)};
        load_cnt_nxt = load_cnt_r + 1'b1;
        if (load_cnt_r == ADDR_W'(NUM_COLS-1)) begin
          tmr_nxt = '0;
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == CNT_W'(COL_SETTLE_CYCLES-1)) begin
          sar_start = 1'b1;
          tmr_nxt = '0;
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        // Bit clock enable derived here; one decision per bit time
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == CNT_W'(BIT_CYCLES-1)) begin
          tmr_nxt = '0;
          sar_step = 1'b1;
        end
        if (ch_done[0]) begin
          state_nxt = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (col_r < last_c) begin
          sel_nxt = {sel_r[NUM_COLS-2:0], 1'b0};
          col_nxt = col_r + 1'b1;
          tmr_nxt = '0;
          state_nxt = ST_SETTLE;
        end else if (scan_repeat_select_i) begin
          col_nxt = first_c;
          sel_nxt = SEL_RST;
          load_cnt_nxt = '0;
          state_nxt = ST_LOAD;
        end else begin
          sel_nxt = SEL_RST;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      sel_r <= SEL_RST;
      col_r <= COL_FIRST_RST;
      load_cnt_r <= '0;
      tmr_r <= '0;
      go_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      col_r <= col_nxt;
      load_cnt_r <= load_cnt_nxt;
      tmr_r <= tmr_nxt;
      go_r <= go_nxt;
    end
  end

  // Switches open during the serial load to avoid stimulating a wrong column
  assign col_sel_o = (state_r == ST_SETTLE || state_r == ST_CONV) ? sel_r : SEL_RST;
  assign measure_go_o = go_r;
  assign busy_o = (state_r != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Row channels
  genvar g;
  generate
    for (g = 0; g < NUM_ROWS; g++) begin : g_ch
      sar_channel u_ch (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(sar_start),
        .step_i(sar_step),
        .cmp_i(cmp_s_r[g]),
        .dac_o(dac_o[g*RES_BITS +: RES_BITS]),
        .result_o(ch_res[g]),
        .done_o(ch_done[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Result hold: copied on column end, so host reads while next column runs
  logic [RES_BITS-1:0] hold_r [NUM_ROWS];
  logic [RES_BITS-1:0] hold_nxt [NUM_ROWS];
  logic [ADDR_W-1:0] hcol_r, hcol_nxt;
  logic hvalid_r, hvalid_nxt;
  logic [RES_BITS-1:0] rd_data_r, rd_data_nxt;
  logic [ADDR_W-1:0] rd_row_r, rd_row_nxt;
  logic done_p_r, done_p_nxt;

  always_comb begin
    hold_nxt = hold_r;
    hcol_nxt = hcol_r;
    hvalid_nxt = hvalid_r;
    done_p_nxt = 1'b0;
    if (ch_done[0]) begin
      hold_nxt = ch_res;
      hcol_nxt = col_r;
      hvalid_nxt = 1'b1;
      done_p_nxt = 1'b1;
    end
    rd_row_nxt = rd_row_i;
    rd_data_nxt = (rd_row_i < ADDR_W'(NUM_ROWS)) ? hold_r[rd_row_i] : RES_RST;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_ROWS; i++) begin
        hold_r[i] <= RES_RST;
      end
      hcol_r <= COL_FIRST_RST;
      hvalid_r <= 1'b0;
      done_p_r <= 1'b0;
      rd_data_r <= RES_RST;
      rd_row_r <= '0;
    end else begin
      hold_r <= hold_nxt;
      hcol_r <= hcol_nxt;
      hvalid_r <= hvalid_nxt;
      done_p_r <= done_p_nxt;
      rd_data_r <= rd_data_nxt;
      rd_row_r <= rd_row_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_row_o = rd_row_r;
  assign rd_col_o = hcol_r;
  assign rd_valid_o = hvalid_r;
  assign col_done_o = done_p_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions; span counts cycles in the current state, too long to unroll as a sequence
  logic [CNT_W-1:0] span_r, span_nxt;
  always_comb begin
    span_nxt = (state_nxt == state_r) ? span_r + 1'b1 : '0;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      span_r <= '0;
    end else begin
      span_r <= span_nxt;
    end
  end

  property p_one_col;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_CONV) |-> $onehot(col_sel_o);
  endproperty
  a_one_col: assert property (p_one_col) else $error("Not exactly one column driven");

  property p_load_len;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_LOAD) |-> (span_r < CNT_W'(NUM_COLS)) &&
        ((state_nxt != ST_LOAD) == (span_r == CNT_W'(NUM_COLS-1)));
  endproperty
  a_load_len: assert property (p_load_len) else $error("Serial load not ten shifts");

  property p_sel_match;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_SETTLE) |-> sel_r[col_r];
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("Selection bit does not match column");

  property p_go_clear;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && go_r && !measure_go_set_i) |=> !go_r ##0 (state_r == ST_LOAD);
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("Start bit not cleared on start");

  property p_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      ch_done[0] |=> (rd_col_o == $past(col_r)) && rd_valid_o && col_done_o;
  endproperty
  a_hold: assert property (p_hold) else $error("Result not held with column");

  property p_all_done;
    @(posedge ref_clk_i) disable iff (rst_i)
      ch_done[0] |-> (&ch_done);
  endproperty
  a_all_done: assert property (p_all_done) else $error("Row channels out of step");

  property p_single;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_NEXT && col_r >= last_c && !scan_repeat_select_i) |=> (state_r == ST_IDLE);
  endproperty
  a_single: assert property (p_single) else $error("Single step did not stop");

  property p_advance;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_NEXT && col_r < last_c) |=> (col_r == $past(col_r) + 4'h1) && (state_r == ST_SETTLE);
  endproperty
  a_advance: assert property (p_advance) else $error("Column did not advance");

  property p_sar_len;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_CONV) |-> (ch_done[0] ? (span_r == CNT_W'(BIT_CYCLES*RES_BITS)) :
        (span_r < CNT_W'(BIT_CYCLES*RES_BITS)));
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("Conversion did not finish");
endmodule

// File: hdl/col_scan_pkg.sv
// Constants and types shared by the column scan sequencer
package col_scan_pkg;
  localparam int NUM_COLS = 10;
  localparam int NUM_ROWS = 10;
  localparam int RES_BITS = 10;
  localparam int ADDR_W = 4;
  localparam logic [RES_BITS-1:0] RES_RST = 10'h000;
  localparam logic [NUM_COLS-1:0] SEL_RST = 10'h000;
  localparam logic [ADDR_W-1:0] COL_FIRST_RST = 4'h0;
  localparam logic [ADDR_W-1:0] COL_LAST_RST = 4'h9;
  // Timing in ns at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_TIME_NS = 3000;
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_SETTLE_NS = 50000;
  localparam int COL_SETTLE_CYCLES = (COL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_LOAD   = 5'b00010,
    ST_SETTLE = 5'b00100,
    ST_CONV   = 5'b01000,
    ST_NEXT   = 5'b10000
  } scan_state_t;
endpackage

// File: hdl/sar_channel.sv
// One row channel: successive approximation register
`timescale 1ns/10ps
module sar_channel
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic step_i,
  input wire logic cmp_i,
  // Outputs
  output logic [col_scan_pkg::RES_BITS-1:0] dac_o,
  output logic [col_scan_pkg::RES_BITS-1:0] result_o,
  output logic done_o
);
  import col_scan_pkg::*;
  logic [RES_BITS-1:0] trial_r, trial_nxt;
  logic [RES_BITS-1:0] mask_r, mask_nxt;
  logic [RES_BITS-1:0] res_r, res_nxt;
  logic done_r, done_nxt;

  always_comb begin
    trial_nxt = trial_r;
    mask_nxt = mask_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    if (start_i) begin
      mask_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
      trial_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (step_i && mask_r != '0) begin
      // Keep the trial bit only when sensor exceeds DAC
      trial_nxt = cmp_i ? trial_r : (trial_r & ~mask_r);
      trial_nxt = trial_nxt | (mask_r >> 1);
      mask_nxt = mask_r >> 1;
      if (mask_r[0]) begin
        res_nxt = cmp_i ? trial_r : (trial_r & ~mask_r);
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trial_r <= RES_RST;
      mask_r <= RES_RST;
      res_r <= RES_RST;
      done_r <= 1'b0;
    end else begin
      trial_r <= trial_nxt;
      mask_r <= mask_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
    end
  end

  assign dac_o = trial_r;
  assign result_o = res_r;
  assign done_o = done_r;
endmodule

// File: tb/sensor_matrix_model.sv
// Behavioural sensor matrix with one comparator per row
`timescale 1ns/10ps
module sensor_matrix_model (
  // Clock
  input wire logic ref_clk_i,
  // Sensor values, row r column c at index r*10+c
  input wire logic [col_scan_pkg::NUM_ROWS*col_scan_pkg::NUM_COLS*col_scan_pkg::RES_BITS-1:0] cap_i,
  // Design side
  input wire logic [col_scan_pkg::NUM_COLS-1:0] col_sel_i,
  input wire logic [col_scan_pkg::NUM_ROWS*col_scan_pkg::RES_BITS-1:0] dac_i,
  output logic [col_scan_pkg::NUM_ROWS-1:0] cmp_o
);
  import col_scan_pkg::*;
  initial cmp_o = '0;
  // Every row compares on its own; no column or a broken selection gives a toggling line
  always @(posedge ref_clk_i) begin : sample
    int col;
    int hits;
    col = 0;
    hits = 0;
    for (int c = 0; c < NUM_COLS; c++) begin
      if (col_sel_i[c]) begin
        col = c;
        hits++;
      end
    end
    for (int r = 0; r < NUM_ROWS; r++) begin
      if (hits == 1) begin
        cmp_o[r] <= cap_i[(r*NUM_COLS+col)*RES_BITS +: RES_BITS] > dac_i[r*RES_BITS +: RES_BITS];
      end else begin
        cmp_o[r] <= ~cmp_o[r];
      end
    end
  end
endmodule

// File: tb/column_scan_sar_sequencer_tb.sv
// Self-checking bench for the column scan sequencer
`timescale 1ns/10ps
module column_scan_sar_sequencer_tb;
  import col_scan_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic measure_go_set_i = 1'b0;
  logic scan_repeat_select_i = 1'b0;
  logic [ADDR_W-1:0] col_first_i = 4'h0;
  logic [ADDR_W-1:0] col_last_i = 4'h9;
  logic [ADDR_W-1:0] rd_row_i = 4'h0;
  logic [NUM_ROWS-1:0] cmp_i;
  logic measure_go_o, busy_o, rd_valid_o, col_done_o;
  logic [NUM_COLS-1:0] col_sel_o;
  logic [NUM_ROWS*RES_BITS-1:0] dac_o;
  logic [RES_BITS-1:0] rd_data_o;
  logic [ADDR_W-1:0] rd_row_o, rd_col_o;
  logic [NUM_ROWS*NUM_COLS*RES_BITS-1:0] cap;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'h05355617;
  always #(CLK_PERIOD_NS/2) ref_clk_i = ~ref_clk_i;
  column_scan_sar_sequencer uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .measure_go_set_i(measure_go_set_i),
    .scan_repeat_select_i(scan_repeat_select_i), .col_first_i(col_first_i), .col_last_i(col_last_i),
    .measure_go_o(measure_go_o), .busy_o(busy_o), .cmp_i(cmp_i), .col_sel_o(col_sel_o), .dac_o(dac_o),
    .rd_row_i(rd_row_i), .rd_data_o(rd_data_o), .rd_row_o(rd_row_o), .rd_col_o(rd_col_o),
    .rd_valid_o(rd_valid_o), .col_done_o(col_done_o));
  sensor_matrix_model matrix (.ref_clk_i(ref_clk_i), .cap_i(cap), .col_sel_i(col_sel_o), .dac_i(dac_o),
    .cmp_o(cmp_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_flag(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic check_word(input logic [RES_BITS-1:0] got, input logic [RES_BITS-1:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Reference conversion: keep a trial bit while the sensor stays above the trial word
  function automatic int sar_model(input int v);
    int res = 0;
    for (int b = RES_BITS-1; b >= 0; b--) begin
      if (v > (res | (1 << b))) res = res | (1 << b);
    end
    return res;
  endfunction
  task automatic fill_caps();
    for (int i = 0; i < NUM_ROWS*NUM_COLS; i++) cap[i*RES_BITS +: RES_BITS] = RES_BITS'($random(seed));
  endtask
  task automatic wait_col_done();
    int k;
    for (k = 0; k < 30000 && col_done_o !== 1'b1; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (k == 30000) begin
      n_errors++;
      $display("BAD %0t no column result", $time);
      conclude();
    end
  endtask
  // Reads every row, one past the last too, while the next column is already running; after the last column of a single pass the sequencer is idle
  task automatic check_column(input int col, input int nxt);
    check_word(rd_col_o, col, "column address");
    check_flag(rd_valid_o, 1'b1, "results valid");
    for (int r = 0; r <= NUM_ROWS; r++) begin
      @(posedge ref_clk_i);
      rd_row_i <= ADDR_W'(r);
      @(posedge ref_clk_i);
      #1;
      check_word(rd_row_o, r, "row echo");
      check_word(rd_data_o, r < NUM_ROWS ? sar_model(cap[(r*NUM_COLS+col)*RES_BITS +: RES_BITS]) : 0,
        "row result");
      if (r < NUM_ROWS) begin
        // The converged trial word stays on the DAC until the next conversion starts
        check_word(dac_o[r*RES_BITS +: RES_BITS], sar_model(cap[(r*NUM_COLS+col)*RES_BITS +: RES_BITS]),
          "final trial word");
      end
    end
    repeat (10) @(posedge ref_clk_i);
    #1;
    check_flag(busy_o, nxt >= 0, "busy after column");
    check_word(col_sel_o, nxt >= 0 ? 1 << nxt : 0, "selected column");
  endtask
  task automatic run_scan(input int first, input int last, input logic rep, input int n_cols);
    int col;
    int nxt;
    @(posedge ref_clk_i);
    col_first_i <= ADDR_W'(first);
    col_last_i <= ADDR_W'(last);
    scan_repeat_select_i <= rep;
    measure_go_set_i <= 1'b1;
    @(posedge ref_clk_i);
    measure_go_set_i <= 1'b0;
    #1;
    check_flag(measure_go_o, 1'b1, "start flag set");
    @(posedge ref_clk_i);
    #1;
    check_flag(measure_go_o, 1'b0, "start flag cleared");
    check_flag(busy_o, 1'b1, "busy after start");
    for (int c = 0; c < n_cols; c++) begin
      wait_col_done();
      col = rep ? first : first + c;
      nxt = rep ? first : (c == n_cols - 1 ? -1 : col + 1);
      check_column(col, nxt);
      // New sensor values before the repeat so a stale result cannot match
      if (rep) fill_caps();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    fill_caps();
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    check_flag(busy_o, 1'b0, "idle after reset");
    check_flag(rd_valid_o, 1'b0, "no results after reset");
    check_word(col_sel_o, 0, "columns grounded after reset");
    run_scan(8, 9, 1'b0, 2);
    $display("test single pass done");
    run_scan(2, 2, 1'b1, 2);
    $display("test continuous done");
    conclude();
  end
endmodule
